// File: design/smc_top.sv
// Serial master controller: register file, pin control and transfer engine
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`include "smc_regs.svh"

// How it works
// RQ1: Runs only when released, enabled, master, pins functional
// RQ2: Select and ready function bits pick option
// RQ3: Software sets wait bit per option
// RQ4: Software keeps fields in legal ranges
// RQ5: Software avoids config changes while enabled
// RQ6: Three-pin option ignores all select delays
// RQ7: Mirror read keeps flags, buffer read clears
// RQ8: Set register ones set output bits
// RQ9: Clear register ones clear output bits
// RQ10: Input register shows every pin level
// RQ11: Per-pin bit picks serial or general
// RQ12: General pins follow direction bits
// RQ13: Four formats, second word selects one
// RQ14: Default register sets idle select level
// RQ15: Hardware inserts setup, hold, gap delays
// RQ16: Control 0 bit low holds module reset
// RQ17: Delay register holds select and ready timing
// RQ18: Vector register names top pending cause
// RQ19: Bit rate is clock over bit_clock_divider+1
// RQ20: Master drives clock, data, select pins
// RQ21: Transmit write starts transfer when running
module smc_top (
  // Clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  // Register port
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [31:0] RDATA_OUT,
  // Serial pins: 0 select, 1 ready, 2 clock, 3 data out, 4 data in
  input  wire logic [4:0]  PIN_IN,
  output logic      [4:0]  PIN_OUT,
  output logic      [4:0]  PIN_OE_OUT
);

  smc_pkg::smc_state_t s;
  smc_pkg::smc_state_t n;
  smc_pkg::smc_state_t z;
  logic [31:0] cf;
  logic [31:0] nf;
  logic [31:0] rdv;
  logic [7:0]  half;
  logic [4:0]  fo;
  logic [4:0]  vec;
  logic [4:0]  pend;
  logic        run;
  logic        csm;
  logic        done;
  logic        tmo;
  logic        act;
  logic        bit_in;
  logic        bit_out;

  // ==================================================
  // Format field decoding
  function automatic logic [7:0] f_pre(input logic [31:0] f);
    f_pre = f[`SMC_FMT_PRE +: 8];
  endfunction : f_pre

  function automatic logic [4:0] f_len(input logic [31:0] f);
    f_len = f[4:0];
  endfunction : f_len

  function automatic logic [8:0] f_gap(input logic [31:0] f);
    f_gap = {3'h0, f[`SMC_FMT_WDLY +: 6]} + `SMC_GAP_EXTRA;
  endfunction : f_gap

  // ==================================================
  // Next state
  always_comb begin
    n       = s;
    z       = '0;
    z.st    = smc_pkg::SMC_IDLE;
    cf      = s.fmt[s.cur_fmt];
    nf      = s.fmt[s.fsel];
    half    = 8'(({1'b0, f_pre(cf)} + 9'h001) >> 1);
    done    = 1'b0;
    tmo     = 1'b0;
    rdv     = 32'h0;
    fo      = 5'h00;
    csm     = s.func[`SMC_PIN_SEL];
    run     = s.rel & s.enable & ~s.loop & s.master & s.clksrc & s.func[`SMC_PIN_CLK]
              & s.func[`SMC_PIN_MOSI] & s.func[`SMC_PIN_MISO]; // [RQ1] [RQ16]
    act     = (s.st != smc_pkg::SMC_IDLE) && (s.st != smc_pkg::SMC_GAP);
    bit_in  = s.lvl[`SMC_PIN_MISO];
    bit_out = cf[`SMC_FMT_LSB] ? s.sh[0] : s.sh[4'(f_len(cf) - 5'h01)];
    // Pin synchronisers
    n.s1 = PIN_IN;
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (s.s2 == s.s3) begin
      n.lvl = s.s3; // [RQ10]
    end
    // Transfer engine
    case (s.st)
      smc_pkg::SMC_IDLE: begin
        if (run && s.tx_pend) begin // [RQ21]
          n.tx_pend  = 1'b0;
          n.sh       = s.txd;
          n.rx       = 16'h0;
          n.cur_fmt  = s.fsel; // [RQ13]
          n.cur_wdel = s.wdel;
          n.bits     = f_len(nf);
          n.div      = 8'h00;
          if (csm && s.dly[`SMC_DLY_C2T +: 8] != 8'h00 && !nf[`SMC_FMT_DISCS]) begin // [RQ6] [RQ15]
            n.st  = smc_pkg::SMC_SETUP;
            n.cnt = {1'b0, s.dly[`SMC_DLY_C2T +: 8]} + `SMC_SETUP_EXTRA;
          end else if (s.func[`SMC_PIN_RDY] && nf[`SMC_FMT_WAIT]) begin // [RQ2]
            n.st  = smc_pkg::SMC_WAITR;
            n.cnt = {1'b0, s.dly[`SMC_DLY_C2E +: 8]};
          end else begin
            n.st = smc_pkg::SMC_SHIFT;
          end
        end
      end
      smc_pkg::SMC_SETUP: begin
        if (s.cnt <= 9'h001) begin
          if (s.func[`SMC_PIN_RDY] && cf[`SMC_FMT_WAIT]) begin
            n.st  = smc_pkg::SMC_WAITR;
            n.cnt = {1'b0, s.dly[`SMC_DLY_C2E +: 8]};
          end else begin
            n.st = smc_pkg::SMC_SHIFT;
          end
        end else begin
          n.cnt = s.cnt - 9'h001;
        end
      end
      smc_pkg::SMC_WAITR: begin
        // Ready is active low; zero time-out waits without limit
        if (!s.lvl[`SMC_PIN_RDY]) begin // [RQ20]
          n.st  = smc_pkg::SMC_SHIFT;
          n.div = 8'h00;
        end else if (s.cnt == 9'h001) begin // [RQ17]
          tmo  = 1'b1;
          n.st = smc_pkg::SMC_IDLE;
        end else if (s.cnt != 9'h000) begin
          n.cnt = s.cnt - 9'h001;
        end
      end
      smc_pkg::SMC_SHIFT: begin
        n.div = s.div + 8'h01;
        if (s.div == half) begin
          n.rx = cf[`SMC_FMT_LSB] ? {bit_in, s.rx[15:1]} : {s.rx[14:0], bit_in};
        end
        if (s.div == f_pre(cf)) begin // [RQ19]
          n.div  = 8'h00;
          n.sh   = cf[`SMC_FMT_LSB] ? {1'b0, s.sh[15:1]} : {s.sh[14:0], 1'b0};
          n.bits = s.bits - 5'h01;
          if (s.bits <= 5'h01) begin
            done  = 1'b1;
            n.rxd = cf[`SMC_FMT_LSB] ? (s.rx >> (5'h10 - f_len(cf))) : s.rx;
            if (csm && s.dly[`SMC_DLY_T2C +: 8] != 8'h00 && !cf[`SMC_FMT_DISCS]) begin // [RQ6] [RQ15]
              n.st  = smc_pkg::SMC_HOLD;
              n.cnt = {1'b0, s.dly[`SMC_DLY_T2C +: 8]} + `SMC_HOLD_EXTRA;
            end else if (s.cur_wdel) begin
              n.st  = smc_pkg::SMC_GAP;
              n.cnt = f_gap(cf);
            end else begin
              n.st = smc_pkg::SMC_IDLE;
            end
          end
        end
      end
      smc_pkg::SMC_HOLD: begin
        if (s.cnt <= 9'h001) begin
          n.st  = s.cur_wdel ? smc_pkg::SMC_GAP : smc_pkg::SMC_IDLE;
          n.cnt = f_gap(cf);
        end else begin
          n.cnt = s.cnt - 9'h001;
        end
      end
      smc_pkg::SMC_GAP: begin
        if (s.cnt <= 9'h001) begin // [RQ15]
          n.st = smc_pkg::SMC_IDLE;
        end else begin
          n.cnt = s.cnt - 9'h001;
        end
      end
      default: begin
        n.st = smc_pkg::SMC_IDLE;
      end
    endcase
    // Pin drive
    fo[`SMC_PIN_SEL]  = (act && csm) ? 1'b0 : s.idle_def; // [RQ14]
    fo[`SMC_PIN_CLK]  = cf[`SMC_FMT_POL] ^ ((s.st == smc_pkg::SMC_SHIFT) &&
                        (cf[`SMC_FMT_PHASE] ? (s.div < half) : (s.div >= half)));
    fo[`SMC_PIN_MOSI] = (s.st == smc_pkg::SMC_SHIFT) & bit_out; // [RQ20]
    n.pin_o  = (s.func & fo) | (~s.func & s.outv); // [RQ11]
    n.pin_oe = (s.func & `SMC_FUNC_OE) | (~s.func & s.dir); // [RQ11] [RQ12]
    // Interrupt vector for line 1
    pend = 5'h00;
    pend[0] = s.flag_ovr & s.int_en[`SMC_FLG_OVR] & s.int_lvl[`SMC_FLG_OVR];
    pend[1] = s.flag_to & s.int_en[`SMC_FLG_TMO] & s.int_lvl[`SMC_FLG_TMO];
    pend[2] = s.flag_rx & s.int_en[`SMC_FLG_RX] & s.int_lvl[`SMC_FLG_RX];
    vec = pend[0] ? `SMC_VEC_OVR : pend[1] ? `SMC_VEC_TMO : pend[2] ? `SMC_VEC_RX : `SMC_VEC_NONE; // [RQ18]
    // Register reads
    case (ADDR_IN)
      `SMC_OFF_GC0:     rdv = {31'h0, s.rel};
      `SMC_OFF_GC1:     rdv = {7'h0, s.enable, 15'h0, s.loop, 6'h0, s.clksrc, s.master};
      `SMC_OFF_INTEN:   rdv = s.int_en;
      `SMC_OFF_INTLVL:  rdv = s.int_lvl;
      `SMC_OFF_FLAGS:   rdv = {22'h0, s.flag_ovr, s.flag_rx, 7'h0, s.flag_to};
      `SMC_OFF_PFUNC:   rdv = {27'h0, s.func};
      `SMC_OFF_PDIR:    rdv = {27'h0, s.dir};
      `SMC_OFF_PIN:     rdv = {27'h0, s.lvl}; // [RQ10]
      `SMC_OFF_POUT:    rdv = {27'h0, s.outv};
      `SMC_OFF_TXW:     rdv = {16'h0, s.txd};
      `SMC_OFF_TXWF:    rdv = {5'h0, s.wdel, s.fsel, 8'h0, s.txd};
      `SMC_OFF_RXBUF,
      `SMC_OFF_RXMIR:   rdv = {~s.flag_rx, s.flag_ovr, 14'h0, s.rxd}; // [RQ7]
      `SMC_OFF_DELAY:   rdv = s.dly;
      `SMC_OFF_IDLEDEF: rdv = {31'h0, s.idle_def};
      `SMC_OFF_FMT0:    rdv = s.fmt[0];
      `SMC_OFF_FMT1:    rdv = s.fmt[1];
      `SMC_OFF_FMT2:    rdv = s.fmt[2];
      `SMC_OFF_FMT3:    rdv = s.fmt[3];
      `SMC_OFF_VEC1:    rdv = {26'h0, vec, 1'b0};
      default:          rdv = 32'h0;
    endcase
    n.rdata = RD_IN ? rdv : 32'h0;
    if (RD_IN && ADDR_IN == `SMC_OFF_RXBUF) begin // [RQ7]
      n.flag_rx  = 1'b0;
      n.flag_ovr = 1'b0;
    end
    // Register writes
    if (WR_IN) begin
      case (ADDR_IN)
        `SMC_OFF_GC0:     n.rel = WDATA_IN[0]; // [RQ16]
        `SMC_OFF_GC1: begin
          n.master = WDATA_IN[`SMC_GC1_MASTER];
          n.clksrc = WDATA_IN[`SMC_GC1_CLKSRC];
          n.loop   = WDATA_IN[`SMC_GC1_LOOP];
          n.enable = WDATA_IN[`SMC_GC1_ENABLE];
        end
        `SMC_OFF_INTEN:   n.int_en = WDATA_IN;
        `SMC_OFF_INTLVL:  n.int_lvl = WDATA_IN;
        `SMC_OFF_FLAGS: begin
          n.flag_to  = s.flag_to & ~WDATA_IN[`SMC_FLG_TMO];
          n.flag_rx  = s.flag_rx & ~WDATA_IN[`SMC_FLG_RX];
          n.flag_ovr = s.flag_ovr & ~WDATA_IN[`SMC_FLG_OVR];
        end
        `SMC_OFF_PFUNC:   n.func = WDATA_IN[4:0]; // [RQ2] [RQ11]
        `SMC_OFF_PDIR:    n.dir = WDATA_IN[4:0]; // [RQ12]
        `SMC_OFF_POUT:    n.outv = WDATA_IN[4:0];
        `SMC_OFF_PSET:    n.outv = s.outv | WDATA_IN[4:0]; // [RQ8]
        `SMC_OFF_PCLR:    n.outv = s.outv & ~WDATA_IN[4:0]; // [RQ9]
        `SMC_OFF_TXW: begin
          n.txd     = WDATA_IN[15:0];
          n.tx_pend = 1'b1; // [RQ21]
        end
        `SMC_OFF_TXWF: begin
          n.txd     = WDATA_IN[15:0];
          n.fsel    = WDATA_IN[`SMC_TXWF_FSEL +: 2]; // [RQ13]
          n.wdel    = WDATA_IN[`SMC_TXWF_WDEL];
          n.tx_pend = 1'b1; // [RQ21]
        end
        `SMC_OFF_DELAY:   n.dly = WDATA_IN; // [RQ17]
        `SMC_OFF_IDLEDEF: n.idle_def = WDATA_IN[0];
        `SMC_OFF_FMT0:    n.fmt[0] = WDATA_IN;
        `SMC_OFF_FMT1:    n.fmt[1] = WDATA_IN;
        `SMC_OFF_FMT2:    n.fmt[2] = WDATA_IN;
        `SMC_OFF_FMT3:    n.fmt[3] = WDATA_IN;
        default:          n.rel = s.rel;
      endcase
    end
    // Hardware sets win over software clears
    if (done) begin
      n.flag_ovr = n.flag_ovr | n.flag_rx;
      n.flag_rx  = 1'b1;
    end
    if (tmo) begin
      n.flag_to = 1'b1;
    end
    // Software reset holds everything but the reset bit, pins and read data
    if (!s.rel) begin // [RQ16]
      z.rel    = n.rel;
      z.s1     = n.s1;
      z.s2     = n.s2;
      z.s3     = n.s3;
      z.lvl    = n.lvl;
      z.pin_o  = n.pin_o;
      z.pin_oe = n.pin_oe;
      z.rdata  = n.rdata;
      n        = z;
    end
  end

  // ==================================================
  // State register
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign RDATA_OUT  = s.rdata;
  assign PIN_OUT    = s.pin_o;
  assign PIN_OE_OUT = s.pin_oe;

  // ==================================================
  // Checks
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  pin_set_a: assert property (WR_IN && ADDR_IN == `SMC_OFF_PSET && s.rel |=> // [RQ8]
    ((s.outv & $past(WDATA_IN[4:0])) == $past(WDATA_IN[4:0])) && ((s.outv & ~$past(WDATA_IN[4:0]))
    == ($past(s.outv) & ~$past(WDATA_IN[4:0])))) else $error("pin set register misbehaves");
  pin_clear_a: assert property (WR_IN && ADDR_IN == `SMC_OFF_PCLR && s.rel |=> // [RQ9]
    (s.outv == ($past(s.outv) & ~$past(WDATA_IN[4:0])))) else $error("pin clear register misbehaves");
  mirror_keep_a: assert property (RD_IN && ADDR_IN == `SMC_OFF_RXMIR && s.flag_rx && s.rel |=> // [RQ7]
    s.flag_rx) else $error("mirror read cleared receive flag");
  buffer_clear_a: assert property (RD_IN && ADDR_IN == `SMC_OFF_RXBUF && !done |=> // [RQ7]
    !s.flag_rx && !s.flag_ovr) else $error("buffer read left receive flags set");
  pin_level_a: assert property (s.s2 == s.s3 ##1 RD_IN && ADDR_IN == `SMC_OFF_PIN |=> // [RQ10]
    RDATA_OUT[4:0] == $past(s.s3, 2)) else $error("pin input register wrong");
  pin_mux_a: assert property (1'b1 |=> PIN_OE_OUT == // [RQ12]
    (($past(s.func) & `SMC_FUNC_OE) | (~$past(s.func) & $past(s.dir)))) else $error("pin direction mux wrong");
  three_pin_a: assert property (!s.func[`SMC_PIN_SEL] |-> // [RQ6]
    s.st != smc_pkg::SMC_SETUP && s.st != smc_pkg::SMC_HOLD) else $error("select delay in three-pin option");
  soft_reset_a: assert property (!s.rel |=> s.st == smc_pkg::SMC_IDLE && !s.tx_pend) // [RQ16]
    else $error("engine active under software reset");
  start_a: assert property (s.st == smc_pkg::SMC_IDLE && run && s.tx_pend |=> // [RQ21]
    s.st != smc_pkg::SMC_IDLE) else $error("transfer did not start");
  bit_rate_a: assert property (s.st == smc_pkg::SMC_SHIFT && s.div == f_pre(cf) && s.bits > 5'h01 |=> // [RQ19]
    s.div == 8'h00 && s.st == smc_pkg::SMC_SHIFT) else $error("bit period wrong");
  idle_select_a: assert property (s.st == smc_pkg::SMC_IDLE && s.func[`SMC_PIN_SEL] |=> // [RQ14]
    PIN_OUT[`SMC_PIN_SEL] == $past(s.idle_def)) else $error("idle select level wrong");

endmodule : smc_top

// File: design/smc_regs.svh
// Register offsets, field positions, output-enable and vector values and timing counts
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
// ==================================================
// Register offsets
`define SMC_OFF_GC0     8'h00
`define SMC_OFF_GC1     8'h04
`define SMC_OFF_INTEN   8'h08
`define SMC_OFF_INTLVL  8'h0c
`define SMC_OFF_FLAGS   8'h10
`define SMC_OFF_PFUNC   8'h14
`define SMC_OFF_PDIR    8'h18
`define SMC_OFF_PIN     8'h1c
`define SMC_OFF_POUT    8'h20
`define SMC_OFF_PSET    8'h24
`define SMC_OFF_PCLR    8'h28
`define SMC_OFF_TXW     8'h38
`define SMC_OFF_TXWF    8'h3c
`define SMC_OFF_RXBUF   8'h40
`define SMC_OFF_RXMIR   8'h44
`define SMC_OFF_DELAY   8'h48
`define SMC_OFF_IDLEDEF 8'h4c
`define SMC_OFF_FMT0    8'h50
`define SMC_OFF_FMT1    8'h54
`define SMC_OFF_FMT2    8'h58
`define SMC_OFF_FMT3    8'h5c
`define SMC_OFF_VEC1    8'h64
// ==================================================
// Field positions
`define SMC_GC1_MASTER  0
`define SMC_GC1_CLKSRC  1
`define SMC_GC1_LOOP    8
`define SMC_GC1_ENABLE  24
`define SMC_FLG_TMO     0
`define SMC_FLG_RX      8
`define SMC_FLG_OVR     9
`define SMC_PIN_SEL     0
`define SMC_PIN_RDY     1
`define SMC_PIN_CLK     2
`define SMC_PIN_MOSI    3
`define SMC_PIN_MISO    4
`define SMC_TXWF_FSEL   24
`define SMC_TXWF_WDEL   26
`define SMC_BUF_OVR     30
`define SMC_BUF_EMPTY   31
`define SMC_DLY_C2T     24
`define SMC_DLY_T2C     16
`define SMC_DLY_C2E     0
`define SMC_FMT_PRE     8
`define SMC_FMT_PHASE   16
`define SMC_FMT_POL     17
`define SMC_FMT_DISCS   18
`define SMC_FMT_LSB     20
`define SMC_FMT_WAIT    21
`define SMC_FMT_WDLY    24
`define SMC_VEC_LO      1
// ==================================================
// Values and counts
`define SMC_FUNC_OE     5'h0d
`define SMC_VEC_NONE    5'h00
`define SMC_VEC_OVR     5'h01
`define SMC_VEC_TMO     5'h02
`define SMC_VEC_RX      5'h03
`define SMC_SETUP_EXTRA 9'h002
`define SMC_HOLD_EXTRA  9'h001
`define SMC_GAP_EXTRA   9'h002
`endif

// File: design/smc_pkg.sv
// Types of the serial master controller
package smc_pkg;
  typedef enum logic [2:0] {SMC_IDLE, SMC_SETUP, SMC_WAITR, SMC_SHIFT, SMC_HOLD, SMC_GAP} smc_st_t;
  typedef struct packed {
    logic             rel;
    logic             master;
    logic             clksrc;
    logic             loop;
    logic             enable;
    logic [31:0]      int_en;
    logic [31:0]      int_lvl;
    logic             flag_to;
    logic             flag_rx;
    logic             flag_ovr;
    logic [4:0]       func;
    logic [4:0]       dir;
    logic [4:0]       outv;
    logic [15:0]      txd;
    logic [1:0]       fsel;
    logic             wdel;
    logic             tx_pend;
    logic [15:0]      rxd;
    logic [31:0]      dly;
    logic             idle_def;
    logic [3:0][31:0] fmt;
    logic [4:0]       s1;
    logic [4:0]       s2;
    logic [4:0]       s3;
    logic [4:0]       lvl;
    logic [4:0]       pin_o;
    logic [4:0]       pin_oe;
    logic [31:0]      rdata;
    smc_st_t          st;
    logic [8:0]       cnt;
    logic [7:0]       div;
    logic [4:0]       bits;
    logic [15:0]      sh;
    logic [15:0]      rx;
    logic [1:0]       cur_fmt;
    logic             cur_wdel;
  } smc_state_t;
endpackage : smc_pkg

// File: test/smc_slave_model.sv
// Serial slave partner: shifts a word out and captures the master's word
`timescale 1ns/1ns
module smc_slave_model (
  // Pins
  input  wire logic        sclk_in,
  input  wire logic        sel_n_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  // Bench control
  input  wire logic        use_sel_in,
  input  wire logic        load_in,
  input  wire logic [15:0] tx_in,
  input  wire logic [4:0]  nbits_in,
  output logic      [15:0] rx_out,
  output int               period_out
);
  logic [15:0] sh = 16'h0000;
  logic        bit_v = 1'b0;
  realtime     t_last = 0;
  wire         act = !use_sel_in || !sel_n_in;
  // Released line shows the inverse of the last bit
  assign miso_out = act ? bit_v : ~bit_v;
  always @(posedge load_in) begin
    sh = tx_in << (16 - nbits_in);
    bit_v = sh[15];
    rx_out = 16'h0000;
  end
  // Clock and data out come from the master
  always @(posedge sclk_in) begin
    if (act) begin
      rx_out = {rx_out[14:0], mosi_in};
      period_out = int'($realtime - t_last);
      t_last = $realtime;
    end
  end
  always @(negedge sclk_in) begin
    if (act) begin
      sh = sh << 1;
      bit_v = sh[15];
    end
  end
endmodule : smc_slave_model

// File: test/testbench.sv
// Self-checking bench of the serial master controller
`timescale 1ns/1ns
`include "smc_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd_s = 1'b0;
  logic [31:0] rdata;
  logic [4:0]  pin_out;
  logic [4:0]  pin_oe;
  logic [4:0]  pin_w;
  logic [3:0]  gpio = 4'h0;
  logic        miso;
  logic        use_sel = 1'b0;
  logic        load = 1'b0;
  logic [15:0] stx = 16'h0;
  logic [4:0]  nbits = 5'h08;
  logic [15:0] srx;
  int          sper;
  int          n_errors = 0;
  int          total_checks = 0;
  logic [31:0] lf = 32'h16;
  logic        sel_seen = 1'b0;
  logic [7:0]  ra [10] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h48, 8'h4c, 8'h50, 8'h5c, 8'h30};
  logic [31:0] rm [10] = '{32'h01000103, 32'hffffffff, 32'hffffffff, 32'h1f, 32'h1f, 32'hffffffff,
                           32'h1, 32'hffffffff, 32'hffffffff, 32'h0};
  // Wire level from all drivers
  assign pin_w = (pin_oe & pin_out) | (~pin_oe & {miso, gpio});
  always #10 clk = ~clk;
  always @(posedge clk) if (pin_oe[0] && !pin_out[0]) sel_seen <= 1'b1;

  smc_top i_smc_top (
    .CLOCK_IN  (clk),
    .RST_IN    (rst),
    .ADDR_IN   (addr),
    .WDATA_IN  (wdata),
    .WR_IN     (wr),
    .RD_IN     (rd_s),
    .RDATA_OUT (rdata),
    .PIN_IN    (pin_w),
    .PIN_OUT   (pin_out),
    .PIN_OE_OUT(pin_oe)
  );
  smc_slave_model i_smc_slave_model (
    .sclk_in   (pin_w[2]),
    .sel_n_in  (pin_w[0]),
    .mosi_in   (pin_w[3]),
    .miso_out  (miso),
    .use_sel_in(use_sel),
    .load_in   (load),
    .tx_in     (stx),
    .nbits_in  (nbits),
    .rx_out    (srx),
    .period_out(sper)
  );

  // ==================================================
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) begin rd_s <= 1'b1; addr <= a; end
    @(posedge clk) rd_s <= 1'b0;
    @(negedge clk) d = rdata;
  endtask : rdr
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic wait_rx(output int cyc);
    logic [31:0] d;
    cyc = 0;
    do begin
      rdr(`SMC_OFF_FLAGS, d);
      cyc += 3;
    end while (d[`SMC_FLG_RX] !== 1'b1 && cyc < 3000);
    if (cyc >= 3000) begin
      n_errors++;
      wrap_up();
    end
  endtask : wait_rx
  task automatic arm(input logic [15:0] v, input logic [4:0] n, input logic s);
    stx = v; nbits = n; use_sel = s;
    load = 1'b1;
    #1 load = 1'b0;
  endtask : arm

  // ==================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [31:0] v;
    logic [4:0]  outv;
    int          cyc;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdr(`SMC_OFF_GC0, d); `CHK("gc0", 32'h0, d)
    wrr(`SMC_OFF_PFUNC, 32'h1f);
    rdr(`SMC_OFF_PFUNC, d); `CHK("held", 32'h0, d)
    wrr(`SMC_OFF_GC0, 32'h1);
    for (int i = 0; i < 10; i++) begin
      rdr(ra[i], d); `CHK("rst val", 32'h0, d)
      lf = nxt(lf);
      wrr(ra[i], lf);
      rdr(ra[i], d); `CHK("rw", lf & rm[i], d)
    end
    // General-purpose pins
    wrr(`SMC_OFF_GC1, 32'h0);
    wrr(`SMC_OFF_PFUNC, 32'h0);
    wrr(`SMC_OFF_PDIR, 32'h0a);
    wrr(`SMC_OFF_POUT, 32'h0);
    lf = nxt(lf); gpio <= lf[3:0];
    lf = nxt(lf); wrr(`SMC_OFF_PSET, lf); outv = lf[4:0];
    lf = nxt(lf); wrr(`SMC_OFF_PCLR, lf); outv &= ~lf[4:0];
    rdr(`SMC_OFF_POUT, d); `CHK("pout", {27'h0, outv}, d)
    `CHK("oe", 5'h0a, pin_oe)
    `CHK("pins", outv & 5'h0a, pin_out & 5'h0a)
    rdr(`SMC_OFF_PIN, d);
    `CHK("pin in", {27'h0, (outv & 5'h0a) | ({miso, gpio} & 5'h15)}, d)
    // Three-pin transfer, delays programmed but ignored
    gpio <= 4'h0;
    wrr(`SMC_OFF_GC1, 32'h3);
    wrr(`SMC_OFF_DELAY, 32'hffffffff);
    wrr(`SMC_OFF_FMT0, 32'h00000f08);
    wrr(`SMC_OFF_PFUNC, 32'h1c);
    wrr(`SMC_OFF_INTEN, 32'h100);
    wrr(`SMC_OFF_INTLVL, 32'h100);
    wrr(`SMC_OFF_GC1, 32'h01000003);
    repeat (4) @(posedge clk);
    lf = nxt(lf); arm(lf[15:0] & 16'hff, 5'd8, 1'b0);
    lf = nxt(lf); v = lf & 32'hff;
    wrr(`SMC_OFF_TXW, v);
    wait_rx(cyc);
    `CHK("no delay", 1'b1, cyc <= 200)
    `CHK("mosi word", v[15:0], srx)
    `CHK("bit period", 320, sper)
    rdr(`SMC_OFF_VEC1, d); `CHK("vector", 5'h03, d[5:1])
    rdr(`SMC_OFF_RXMIR, d); `CHK("mirror", stx, d[15:0])
    rdr(`SMC_OFF_FLAGS, d); `CHK("kept", 1'b1, d[`SMC_FLG_RX])
    rdr(`SMC_OFF_RXBUF, d); `CHK("rxbuf", stx, d[15:0])
    rdr(`SMC_OFF_FLAGS, d); `CHK("cleared", 1'b0, d[`SMC_FLG_RX])
    // Four-pin select, second format, hardware delays
    wrr(`SMC_OFF_GC1, 32'h3);
    wrr(`SMC_OFF_DELAY, 32'h40040000);
    wrr(`SMC_OFF_IDLEDEF, 32'h1);
    wrr(`SMC_OFF_FMT1, 32'h00000b05);
    wrr(`SMC_OFF_PFUNC, 32'h1d);
    wrr(`SMC_OFF_GC1, 32'h01000003);
    repeat (4) @(posedge clk);
    `CHK("idle sel", 2'b11, {pin_oe[0], pin_out[0]})
    sel_seen <= 1'b0;
    lf = nxt(lf); arm(lf[15:0] & 16'h1f, 5'd5, 1'b1);
    lf = nxt(lf); v = lf & 32'h1f;
    wrr(`SMC_OFF_TXWF, 32'h01000000 | v);
    wait_rx(cyc);
    `CHK("sel low", 1'b1, sel_seen)
    `CHK("setup", 1'b1, cyc >= 100)
    `CHK("fmt1 word", v[15:0], srx)
    `CHK("fmt1 period", 240, sper)
    repeat (20) @(posedge clk);
    `CHK("sel back", 1'b1, pin_out[0])
    rdr(`SMC_OFF_RXBUF, d);
    // Loopback blocks a transfer
    wrr(`SMC_OFF_GC1, 32'h01000103);
    wrr(`SMC_OFF_TXW, 32'h5);
    repeat (200) @(posedge clk);
    rdr(`SMC_OFF_FLAGS, d); `CHK("loop", 1'b0, d[`SMC_FLG_RX])
    // Software reset clears the rest
    wrr(`SMC_OFF_GC0, 32'h0);
    wrr(`SMC_OFF_GC0, 32'h1);
    rdr(`SMC_OFF_FMT1, d); `CHK("sw reset", 32'h0, d)
    wrap_up();
  end
endmodule : testbench
